//--- core/psr_pkg.sv
// Purpose: Shared constants and types of the converter status and control bank
// Assumes: Byte-wide command codes on a two-wire management link
// Notes:   Condition bit indices address the i_cond vector of psr_regs
package psr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_ON_OFF = 8'h01;
  localparam logic [7:0] CMD_CLR    = 8'h03;
  localparam logic [7:0] CMD_WP     = 8'h10;
  localparam logic [7:0] CMD_STORE  = 8'h11;
  localparam logic [7:0] CMD_VOUT   = 8'h21;
  localparam logic [7:0] CMD_SBYTE  = 8'h78;
  localparam logic [7:0] CMD_SWORD  = 8'h79;
  localparam logic [7:0] CMD_SVO    = 8'h7a;
  localparam logic [7:0] CMD_SIO    = 8'h7b;
  localparam logic [7:0] CMD_SVI    = 8'h7c;
  localparam logic [7:0] CMD_STMP   = 8'h7d;
  localparam logic [7:0] CMD_SMFR   = 8'h80;
  localparam logic [7:0] CMD_SFAN   = 8'h81;

  ////////////////////////////////////////////////////////////////////////////
  // Data values and reset values
  localparam logic [7:0] ON_VAL   = 8'h80;
  localparam logic [7:0] OFF_VAL  = 8'h00;
  localparam logic [7:0] WP_ALL   = 8'h00;
  localparam logic [7:0] WP_NONE  = 8'h80;
  localparam logic [7:0] WP_ONOFF = 8'h40;
  localparam logic [7:0] WP_RST   = 8'h80;
  localparam logic       ON_RST   = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Condition vector layout
  localparam int C_VO_OVF = 0;
  localparam int C_VO_OVW = 1;
  localparam int C_VO_UVW = 2;
  localparam int C_VO_UVF = 3;
  localparam int C_IO_OCF = 4;
  localparam int C_IO_OCW = 5;
  localparam int C_VI_OVF = 6;
  localparam int C_VI_OVW = 7;
  localparam int C_VI_UVW = 8;
  localparam int C_VI_UVF = 9;
  localparam int C_OTF    = 10;
  localparam int C_OTW    = 11;
  localparam int C_FAN1F  = 12;
  localparam int C_FAN2F  = 13;
  localparam int C_FAN1O  = 14;
  localparam int C_FAN2O  = 15;
  localparam int C_STBYF  = 16;
  localparam int C_BUSY   = 17;
  localparam int C_RMT    = 18;
  localparam int C_HWEN   = 19;
  localparam int NCOND    = 20;
  localparam int NFLT     = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Link request kinds and byte counts
  localparam logic       KIND_PTR  = 1'b0;
  localparam logic       KIND_EXEC = 1'b1;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [1:0] NB_SEND   = 2'h1;
  localparam logic [1:0] NB_BYTE   = 2'h2;
  localparam logic [1:0] NB_WORD   = 2'h3;

  typedef enum logic [3:0] {
    PSR_IDLE = 4'h0,
    PSR_ADDR = 4'h1,
    PSR_AACK = 4'h3,
    PSR_RXB  = 4'h2,
    PSR_RACK = 4'h6,
    PSR_TXB  = 4'h7,
    PSR_TACK = 4'h5
  } psr_lst_t;

endpackage

//--- core/psr_regs.sv
// Purpose: Status and control register bank behind a two-wire management link
// Assumes: i_clk_link oversamples SCL/SDA; SCL at most 1 MHz
// Notes:   Link side on i_clk_link, register bank on i_clk_sys
//
// Summary of operation
// - Status byte: busy, off, OV, OC, UV, temp, comm, other
// - Word high byte: vout, iout, input, mfr, off, fan
// - Vout status: OV fault/warn, UV warn/fault bits 7-4
// - Iout status: OC fault bit 7, warning bit 5
// - Input status: OV fault/warn, UV warn/fault bits 7-4
// - Temperature status: OT fault 7, warning 6
// - Fan status: faults bits 7,6; overrides 3,2
// - Maker status: standby, interrupt, fault, remote, rail, input
// - Unit on after power-up when enable pin high
// - On/off command: 0x80 on, 0x00 off
// - Off-then-on restart clears alarms and latched shutdowns
// - Clear-faults zeroes status and releases alert
// - Persisting fault sets status and alert again
// - Reads succeed whatever the write-protect level
// - Write-protect levels 0x00, 0x80, 0x40 gate writes
// - Write-protect resets to 0x80
// - Store-defaults saves write-protect to non-volatile memory
// - Output voltage command sets the set point
// - Word low byte equals status byte
// - Unsupported command or bad data flags comm, alert
// - Unsupported read returns zero bytes
`timescale 1ns/10ps
module psr_regs #(
  parameter logic [6:0]  P_ADDR = 7'h58,
  parameter logic [15:0] P_VOUT = 16'h1800
) (
  // Clocks and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_nrst,
  input  wire logic                      i_clk_link,
  // Two-wire link
  input  wire logic                      i_scl,
  input  wire logic                      i_sda,
  output logic                           o_sda_out,
  output logic                           o_sda_oe_n,
  // Alert line
  output logic                           o_alert_out,
  output logic                           o_alert_oe_n,
  // Converter side
  input  wire logic [psr_pkg::NCOND-1:0] i_cond,
  output logic                           o_out_en,
  output logic [15:0]                    o_vout_set,
  // Non-volatile store
  output logic                           o_nvm_store,
  output logic [7:0]                     o_nvm_wp
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]       p1;
    logic [1:0]       p2;
    logic [1:0]       p3;
    logic [1:0]       pf;
    psr_pkg::psr_lst_t st;
    logic [3:0]       bcnt;
    logic [7:0]       sh;
    logic             rw;
    logic [1:0]       nb;
    logic             pend;
    logic [7:0]       cmd;
    logic [7:0]       d0;
    logic [7:0]       d1;
    logic             kind;
    logic             req_tg;
    logic [1:0]       ak;
    logic             ak_last;
    logic [7:0]       tsh;
    logic             hi;
    logic [15:0]      txd;
    logic             sda_oe_n;
    logic             sda_o;
  } psr_link_t;

  typedef struct packed {
    logic [psr_pkg::NCOND-1:0] c1;
    logic [psr_pkg::NCOND-1:0] c2;
    logic [psr_pkg::NCOND-1:0] c3;
    logic [psr_pkg::NCOND-1:0] cf;
    logic [1:0]                rq;
    logic                      rq_last;
    logic                      ack_tg;
    logic [psr_pkg::NFLT-1:0]  stk;
    logic                      cml;
    logic                      on;
    logic [7:0]                wp;
    logic [15:0]               vout;
    logic [15:0]               rd;
    logic                      out_en;
    logic                      store;
    logic                      alert_oe_n;
    logic                      alert_o;
  } psr_sys_t;

  psr_link_t l_r;
  psr_link_t l_nxt;
  psr_sys_t  s_r;
  psr_sys_t  s_nxt;

  logic [1:0]  lpf;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        ev;
  logic        clr;
  logic [7:0]  svo;
  logic [7:0]  sio;
  logic [7:0]  svi;
  logic [7:0]  stmp;
  logic [7:0]  sfan;
  logic [7:0]  smfr;
  logic [7:0]  sbyte;
  logic [7:0]  whi;
  logic [15:0] rd_val;
  logic        flt_any;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic supp(input logic [7:0] c);
    case (c)
      psr_pkg::CMD_ON_OFF, psr_pkg::CMD_CLR, psr_pkg::CMD_WP, psr_pkg::CMD_STORE,
      psr_pkg::CMD_VOUT, psr_pkg::CMD_SBYTE, psr_pkg::CMD_SWORD, psr_pkg::CMD_SVO,
      psr_pkg::CMD_SIO, psr_pkg::CMD_SVI, psr_pkg::CMD_STMP, psr_pkg::CMD_SMFR,
      psr_pkg::CMD_SFAN: supp = 1'b1;
      default: supp = 1'b0;
    endcase
  endfunction

  function automatic logic wr_ok(input logic [7:0] c, input logic [7:0] wp);
    case (wp)
      psr_pkg::WP_ALL:   wr_ok = 1'b1;
      psr_pkg::WP_ONOFF: wr_ok = (c == psr_pkg::CMD_WP) || (c == psr_pkg::CMD_ON_OFF);
      default:           wr_ok = (c == psr_pkg::CMD_WP);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: pin filter and byte engine
  assign lpf      = (~(l_r.p2 ^ l_r.p3) & l_r.p3) | ((l_r.p2 ^ l_r.p3) & l_r.pf);
  assign scl_rise = lpf[1] & ~l_r.pf[1];
  assign scl_fall = ~lpf[1] & l_r.pf[1];
  assign start_c  = lpf[1] & l_r.pf[1] & l_r.pf[0] & ~lpf[0];
  assign stop_c   = lpf[1] & l_r.pf[1] & ~l_r.pf[0] & lpf[0];

  always_comb
  begin
    l_nxt    = l_r;
    l_nxt.p1 = {i_scl, i_sda};
    l_nxt.p2 = l_r.p1;
    l_nxt.p3 = l_r.p2;
    l_nxt.pf = lpf;
    l_nxt.ak = {l_r.ak[0], s_r.ack_tg};
    l_nxt.ak_last = l_r.ak[1];
    if (l_r.ak[1] ^ l_r.ak_last)
    begin
      l_nxt.txd = s_r.rd;
    end
    if (start_c)
    begin
      l_nxt.st       = psr_pkg::PSR_ADDR;
      l_nxt.bcnt     = 4'h0;
      l_nxt.pend     = 1'b0;
      l_nxt.nb       = 2'h0;
      l_nxt.sda_oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      if (l_r.pend)
      begin
        l_nxt.kind   = psr_pkg::KIND_EXEC;
        l_nxt.req_tg = ~l_r.req_tg;
      end
      l_nxt.pend     = 1'b0;
      l_nxt.st       = psr_pkg::PSR_IDLE;
      l_nxt.sda_oe_n = 1'b1;
    end
    else
    begin
      case (l_r.st)
        psr_pkg::PSR_ADDR, psr_pkg::PSR_RXB:
        begin
          if (scl_rise)
          begin
            l_nxt.sh   = {l_r.sh[6:0], lpf[0]};
            l_nxt.bcnt = l_r.bcnt + 4'h1;
          end
          else if (scl_fall && l_r.bcnt == psr_pkg::BITS_BYTE)
          begin
            l_nxt.sda_oe_n = 1'b0;
            if (l_r.st == psr_pkg::PSR_ADDR)
            begin
              l_nxt.rw = l_r.sh[0];
              l_nxt.st = psr_pkg::PSR_AACK;
              if (l_r.sh[7:1] != P_ADDR)
              begin
                l_nxt.st       = psr_pkg::PSR_IDLE;
                l_nxt.sda_oe_n = 1'b1;
              end
            end
            else
            begin
              l_nxt.st = psr_pkg::PSR_RACK;
              if (l_r.nb != psr_pkg::NB_WORD)
              begin
                l_nxt.nb = l_r.nb + 2'h1;
              end
              l_nxt.pend = 1'b1;
              case (l_r.nb)
                2'h0:
                begin
                  l_nxt.cmd    = l_r.sh;
                  l_nxt.kind   = psr_pkg::KIND_PTR;
                  l_nxt.req_tg = ~l_r.req_tg;
                end
                2'h1:    l_nxt.d0 = l_r.sh;
                2'h2:    l_nxt.d1 = l_r.sh;
                default: l_nxt.pend = 1'b1;
              endcase
            end
          end
        end
        psr_pkg::PSR_AACK:
        begin
          if (scl_fall)
          begin
            l_nxt.bcnt = 4'h0;
            l_nxt.st   = psr_pkg::PSR_RXB;
            l_nxt.sda_oe_n = 1'b1;
            if (l_r.rw)
            begin
              l_nxt.st       = psr_pkg::PSR_TXB;
              l_nxt.bcnt     = 4'h1;
              l_nxt.hi       = 1'b0;
              l_nxt.sda_oe_n = l_r.txd[7];
              l_nxt.tsh      = {l_r.txd[6:0], 1'b1};
            end
          end
        end
        psr_pkg::PSR_RACK:
        begin
          if (scl_fall)
          begin
            l_nxt.st       = psr_pkg::PSR_RXB;
            l_nxt.bcnt     = 4'h0;
            l_nxt.sda_oe_n = 1'b1;
          end
        end
        psr_pkg::PSR_TXB:
        begin
          if (scl_fall)
          begin
            if (l_r.bcnt == psr_pkg::BITS_BYTE)
            begin
              l_nxt.sda_oe_n = 1'b1;
              l_nxt.st       = psr_pkg::PSR_TACK;
            end
            else
            begin
              l_nxt.sda_oe_n = l_r.tsh[7];
              l_nxt.tsh      = {l_r.tsh[6:0], 1'b1};
              l_nxt.bcnt     = l_r.bcnt + 4'h1;
            end
          end
        end
        psr_pkg::PSR_TACK:
        begin
          if (scl_rise)
          begin
            l_nxt.rw = ~lpf[0];
          end
          else if (scl_fall)
          begin
            l_nxt.st = psr_pkg::PSR_IDLE;
            if (l_r.rw)
            begin
              // Low byte first, then high byte, then zeros
              l_nxt.st       = psr_pkg::PSR_TXB;
              l_nxt.bcnt     = 4'h1;
              l_nxt.hi       = 1'b1;
              l_nxt.sda_oe_n = l_r.hi ? 1'b0 : l_r.txd[15];
              l_nxt.tsh      = l_r.hi ? 8'h01 : {l_r.txd[14:8], 1'b1};
            end
          end
        end
        default: l_nxt.st = psr_pkg::PSR_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_link or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      l_r          <= '0;
      l_r.p1       <= 2'h3;
      l_r.p2       <= 2'h3;
      l_r.p3       <= 2'h3;
      l_r.pf       <= 2'h3;
      l_r.st       <= psr_pkg::PSR_IDLE;
      l_r.sda_oe_n <= 1'b1;
    end
    else
    begin
      l_r <= l_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: status assembly
  assign svo  = {s_r.stk[psr_pkg::C_VO_OVF], s_r.stk[psr_pkg::C_VO_OVW],
                 s_r.stk[psr_pkg::C_VO_UVW], s_r.stk[psr_pkg::C_VO_UVF], 4'h0};
  assign sio  = {s_r.stk[psr_pkg::C_IO_OCF], 1'b0, s_r.stk[psr_pkg::C_IO_OCW], 5'h00};
  assign svi  = {s_r.stk[psr_pkg::C_VI_OVF], s_r.stk[psr_pkg::C_VI_OVW],
                 s_r.stk[psr_pkg::C_VI_UVW], s_r.stk[psr_pkg::C_VI_UVF], 4'h0};
  assign stmp = {s_r.stk[psr_pkg::C_OTF], s_r.stk[psr_pkg::C_OTW], 6'h00};
  assign sfan = {s_r.stk[psr_pkg::C_FAN1F], s_r.stk[psr_pkg::C_FAN2F], 2'h0,
                 s_r.stk[psr_pkg::C_FAN1O], s_r.stk[psr_pkg::C_FAN2O], 2'h0};
  assign flt_any = svo[7] | svo[4] | sio[7] | svi[7] | svi[4] | stmp[7] | sfan[7] | sfan[6]
                 | s_r.stk[psr_pkg::C_STBYF];
  assign smfr = {s_r.stk[psr_pkg::C_STBYF], 1'b0, ~s_r.alert_oe_n, flt_any,
                 s_r.cf[psr_pkg::C_RMT], svo[7] | svo[4] | sio[7], svi[7] | svi[4], 1'b0};
  assign whi  = {|svo, |sio, |svi, s_r.stk[psr_pkg::C_STBYF], ~s_r.on, |sfan, 2'h0};
  assign sbyte = {s_r.cf[psr_pkg::C_BUSY], ~s_r.on, svo[7], sio[7], svi[4], |stmp, s_r.cml,
                  |{svo[6:4], sio[5], svi[7:5], sfan, s_r.stk[psr_pkg::C_STBYF]}};

  always_comb
  begin
    case (l_r.cmd)
      psr_pkg::CMD_ON_OFF: rd_val = {8'h00, s_r.on ? psr_pkg::ON_VAL : psr_pkg::OFF_VAL};
      psr_pkg::CMD_WP:     rd_val = {8'h00, s_r.wp};
      psr_pkg::CMD_VOUT:   rd_val = s_r.vout;
      psr_pkg::CMD_SBYTE:  rd_val = {8'h00, sbyte};
      psr_pkg::CMD_SWORD:  rd_val = {whi, sbyte};
      psr_pkg::CMD_SVO:    rd_val = {8'h00, svo};
      psr_pkg::CMD_SIO:    rd_val = {8'h00, sio};
      psr_pkg::CMD_SVI:    rd_val = {8'h00, svi};
      psr_pkg::CMD_STMP:   rd_val = {8'h00, stmp};
      psr_pkg::CMD_SMFR:   rd_val = {8'h00, smfr};
      psr_pkg::CMD_SFAN:   rd_val = {8'h00, sfan};
      default:             rd_val = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: command execution
  assign ev = s_r.rq[1] ^ s_r.rq_last;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.c1    = i_cond;
    s_nxt.c2    = s_r.c1;
    s_nxt.c3    = s_r.c2;
    s_nxt.cf    = (~(s_r.c2 ^ s_r.c3) & s_r.c3) | ((s_r.c2 ^ s_r.c3) & s_r.cf);
    s_nxt.rq    = {s_r.rq[0], l_r.req_tg};
    s_nxt.rq_last = s_r.rq[1];
    s_nxt.store = 1'b0;
    clr         = 1'b0;
    if (ev && l_r.kind == psr_pkg::KIND_PTR)
    begin
      s_nxt.rd     = rd_val;
      s_nxt.ack_tg = ~s_r.ack_tg;
      if (!supp(l_r.cmd))
      begin
        s_nxt.cml = 1'b1;
      end
    end
    else if (ev)
    begin
      s_nxt.cml = 1'b1;
      if (l_r.nb == psr_pkg::NB_SEND && l_r.cmd == psr_pkg::CMD_CLR)
      begin
        s_nxt.cml = s_r.cml;
        clr       = 1'b1;
      end
      else if (l_r.nb == psr_pkg::NB_SEND && l_r.cmd == psr_pkg::CMD_STORE)
      begin
        s_nxt.cml   = s_r.cml;
        s_nxt.store = 1'b1;
      end
      else if (l_r.nb == psr_pkg::NB_BYTE && l_r.cmd == psr_pkg::CMD_ON_OFF
               && (l_r.d0 == psr_pkg::ON_VAL || l_r.d0 == psr_pkg::OFF_VAL))
      begin
        s_nxt.cml = s_r.cml;
        if (wr_ok(l_r.cmd, s_r.wp))
        begin
          s_nxt.on = (l_r.d0 == psr_pkg::ON_VAL);
        end
      end
      else if (l_r.nb == psr_pkg::NB_BYTE && l_r.cmd == psr_pkg::CMD_WP
               && (l_r.d0 == psr_pkg::WP_ALL || l_r.d0 == psr_pkg::WP_NONE
                   || l_r.d0 == psr_pkg::WP_ONOFF))
      begin
        s_nxt.cml = s_r.cml;
        s_nxt.wp  = l_r.d0;
      end
      else if (l_r.nb == psr_pkg::NB_WORD && l_r.cmd == psr_pkg::CMD_VOUT)
      begin
        s_nxt.cml = s_r.cml;
        if (wr_ok(l_r.cmd, s_r.wp))
        begin
          s_nxt.vout = {l_r.d1, l_r.d0};
        end
      end
    end
    if (s_nxt.on && !s_r.on)
    begin
      clr = 1'b1;
    end
    if (clr)
    begin
      s_nxt.cml = 1'b0;
    end
    // Live condition wins over a clear in the same cycle
    s_nxt.stk = (s_r.stk & {psr_pkg::NFLT{~clr}}) | s_r.cf[psr_pkg::NFLT-1:0];
    s_nxt.alert_oe_n = ~(|s_nxt.stk | s_nxt.cml);
    s_nxt.out_en = s_r.on & s_r.cf[psr_pkg::C_HWEN] & ~s_r.stk[psr_pkg::C_VO_OVF];
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_r            <= '0;
      s_r.on         <= psr_pkg::ON_RST;
      s_r.wp         <= psr_pkg::WP_RST;
      s_r.vout       <= P_VOUT;
      s_r.alert_oe_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_sda_out    = l_r.sda_o;
  assign o_sda_oe_n   = l_r.sda_oe_n;
  assign o_alert_out  = s_r.alert_o;
  assign o_alert_oe_n = s_r.alert_oe_n;
  assign o_out_en     = s_r.out_en;
  assign o_vout_set   = s_r.vout;
  assign o_nvm_store  = s_r.store;
  assign o_nvm_wp     = s_r.wp;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  logic        ex;
  logic [15:0] nfl;
  assign ex  = ev && l_r.kind == psr_pkg::KIND_EXEC;
  assign nfl = s_r.cf[15:0];

  property p_clear;
    ex && l_r.nb == psr_pkg::NB_SEND && l_r.cmd == psr_pkg::CMD_CLR && !(|s_r.cf[16:0])
      |=> s_r.stk == '0 ##1 o_alert_oe_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not release status");

  property p_reassert;
    ex && l_r.nb == psr_pkg::NB_SEND && l_r.cmd == psr_pkg::CMD_CLR && (|nfl)
      |=> ##[0:1] !o_alert_oe_n;
  endproperty
  a_reassert: assert property (p_reassert) else $error("alert not reasserted");

  property p_on_off;
    ex && l_r.nb == psr_pkg::NB_BYTE && l_r.cmd == psr_pkg::CMD_ON_OFF
      && l_r.d0 == psr_pkg::OFF_VAL && s_r.wp != psr_pkg::WP_NONE
      |=> !s_r.on ##1 !o_out_en;
  endproperty
  a_on_off: assert property (p_on_off) else $error("off command ignored");

  property p_guard;
    ex && l_r.cmd == psr_pkg::CMD_VOUT && s_r.wp != psr_pkg::WP_ALL |=> $stable(o_vout_set);
  endproperty
  a_guard: assert property (p_guard) else $error("protected write changed vout");

  property p_vout;
    ex && l_r.nb == psr_pkg::NB_WORD && l_r.cmd == psr_pkg::CMD_VOUT && s_r.wp == psr_pkg::WP_ALL
      |=> o_vout_set == {$past(l_r.d1), $past(l_r.d0)};
  endproperty
  a_vout: assert property (p_vout) else $error("vout not written");

  property p_wp_self;
    ex && l_r.nb == psr_pkg::NB_BYTE && l_r.cmd == psr_pkg::CMD_WP && l_r.d0 == psr_pkg::WP_ALL
      |=> o_nvm_wp == psr_pkg::WP_ALL;
  endproperty
  a_wp_self: assert property (p_wp_self) else $error("protect level not written");

  property p_restart;
    !s_r.on ##1 s_r.on && !(|s_r.cf[16:0]) |-> s_r.stk == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart kept alarms");

  property p_unsup;
    ev && l_r.kind == psr_pkg::KIND_PTR && !supp(l_r.cmd) |=> s_r.rd == 16'h0000 && s_r.cml
      ##1 !o_alert_oe_n;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported read mishandled");

  property p_store;
    ex && l_r.nb == psr_pkg::NB_SEND && l_r.cmd == psr_pkg::CMD_STORE
      |=> o_nvm_store ##1 !o_nvm_store;
  endproperty
  a_store: assert property (p_store) else $error("store pulse wrong");

  property p_hwen;
    !s_r.cf[psr_pkg::C_HWEN] [*2] |-> !o_out_en;
  endproperty
  a_hwen: assert property (p_hwen) else $error("output on without enable");

  c_clear: cover property (ex && l_r.cmd == psr_pkg::CMD_CLR);
  c_ptr:   cover property (ev && l_r.kind == psr_pkg::KIND_PTR && l_r.cmd == psr_pkg::CMD_SWORD);
  c_on:    cover property (!s_r.on ##[1:1000] s_r.on);
  c_store: cover property (o_nvm_store);

endmodule

//--- tb/psr_host.sv
// Purpose: Host model driving the two-wire link
// Assumes: Pull-up on SDA; only the host drives SCL
// Notes:   1 MHz bit rate; SCL stands high between frames
`timescale 1ns/10ps
module psr_host (
  // Link pins
  output logic      o_scl = 1'b1,
  output logic      o_sda_low = 1'b0,
  input  wire logic i_sda
);
  localparam int Q = 250;
  ////////////////////////////////////////////////////////////////////////////
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic l, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(l, a);
  endtask
  // Start when s is 1, stop when s is 0
  task automatic frame_edge(input logic s);
    o_sda_low = !s;
    #(4*Q) o_scl = 1'b1;
    #Q o_sda_low = s;
    #Q o_scl = !s;
    #Q;
  endtask
  // Single unit on the link, so set point writes land together
  // Byte counts follow the command code
  task automatic xfer(input logic [7:0] c, input logic [15:0] d, output logic [15:0] rd);
    logic [7:0] r;
    logic       a;
    int         nw, nr;
    nw = (c == 8'h21) ? 2 : int'(c == 8'h01 || c == 8'h10);
    nr = (c == 8'h79 || c == 8'h99) ? 2 : int'(c >= 8'h78);
    rd = 16'h0000;
    frame_edge(1'b1);
    byte_io({7'h58, 1'b0}, 1'b1, r, a);
    byte_io(c, 1'b1, r, a);
    for (int i = 0; i < nw; i++)
      byte_io(d[8*i+:8], 1'b1, r, a);
    if (nr > 0)
    begin
      frame_edge(1'b1);
      byte_io({7'h58, 1'b1}, 1'b1, r, a);
    end
    for (int i = 0; i < nr; i++)
      byte_io(8'hff, i == nr - 1, rd[8*i+:8], a);
    frame_edge(1'b0);
  endtask
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench of the status and control bank
// Assumes: Host model on the link; pull-ups on SDA and alert
// Notes:   Restart off time shortened to microseconds
`timescale 1ns/10ps
module tb;
  typedef struct packed {logic [19:0] c; logic [7:0] m; logic [15:0] d, e;
                         logic [2:0] f;} psr_row_t;
  localparam logic [19:0] H = 20'h80000;
  localparam logic [19:0] A = 20'hbfffe;
  logic        i_clk_sys = 1'b0, i_clk_link = 1'b0, i_nrst = 1'b0;
  logic        scl, sda_low, sda, sda_out, sda_oe_n, al_out, al_oe_n, out_en, store;
  logic [19:0] i_cond = H;
  logic [15:0] rd, vset;
  logic [7:0]  nvm_wp;
  int          bad_count = 0, n_compared = 0, cyc = 0, n_store = 0;
  // Flags: output on, alert released, set point written
  psr_row_t    rows [25] = '{
    '{20'hc0000, 8'h80, 16'h0, 16'h0008, 3'h6},
    '{A, 8'h7a, 16'h0, 16'h0070, 3'h4},
    '{A, 8'h7b, 16'h0, 16'h00a0, 3'h4},
    '{A, 8'h7c, 16'h0, 16'h00f0, 3'h4},
    '{A, 8'h7d, 16'h0, 16'h00c0, 3'h4},
    '{A, 8'h81, 16'h0, 16'h00cc, 3'h4},
    '{A, 8'h78, 16'h0, 16'h009d, 3'h4},
    '{A, 8'h79, 16'h0, 16'hf49d, 3'h4},
    '{A, 8'h03, 16'h0, 16'h0000, 3'h4},
    '{A, 8'h7c, 16'h0, 16'h00f0, 3'h4},
    '{H, 8'h03, 16'h0, 16'h0000, 3'h6},
    '{H, 8'h01, 16'h0, 16'h0000, 3'h6},
    '{H, 8'h21, 16'h1234, 16'h0, 3'h6},
    '{H, 8'h10, 16'h0040, 16'h0, 3'h6},
    '{H, 8'h01, 16'h0, 16'h0000, 3'h2},
    '{H, 8'h78, 16'h0, 16'h0040, 3'h2},
    '{H, 8'h10, 16'h0, 16'h0000, 3'h2},
    '{H, 8'h21, 16'h1234, 16'h0, 3'h3},
    '{H, 8'h01, 16'h0080, 16'h0, 3'h7},
    '{20'h80001, 8'h7a, 16'h0, 16'h0080, 3'h1},
    '{H, 8'h01, 16'h0, 16'h0000, 3'h1},
    '{H, 8'h01, 16'h0080, 16'h0, 3'h7}, // Off time shortened
    '{H, 8'h11, 16'h0, 16'h0000, 3'h7},
    '{H, 8'h99, 16'h0, 16'h0000, 3'h5},
    '{20'h00000, 8'h78, 16'h0, 16'h0002, 3'h1}
  };
  assign sda = !sda_low && (sda_oe_n || sda_out);
  ////////////////////////////////////////////////////////////////////////////
  psr_regs psr_regs_i (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_clk_link(i_clk_link), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_alert_out(al_out),
    .o_alert_oe_n(al_oe_n), .i_cond(i_cond), .o_out_en(out_en), .o_vout_set(vset),
    .o_nvm_store(store), .o_nvm_wp(nvm_wp)
  );
  psr_host psr_host_i (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial forever #4 i_clk_sys = ~i_clk_sys;
  initial #5 forever #16 i_clk_link = ~i_clk_link;
  always @(posedge i_clk_sys)
  begin
    cyc = cyc + 1;
    n_store = n_store + int'(store === 1'b1);
    if (cyc == 150000)
    begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    chk("wp", 16'h0080, 16'(nvm_wp));
    #1 i_nrst = 1'b1;
    foreach (rows[k])
    begin
      @(posedge i_clk_sys);
      #1 i_cond = rows[k].c;
      psr_host_i.xfer(rows[k].m, rows[k].d, rd);
      repeat (20) @(posedge i_clk_sys);
      #1 chk("rd", rows[k].e, rd);
      chk("on", 16'(rows[k].f[2]), 16'(out_en));
      chk("alert", 16'(rows[k].f[1]), 16'(al_oe_n));
      chk("vset", rows[k].f[0] ? 16'h1234 : 16'h1800, vset);
    end
    chk("store", 16'h0001, 16'(n_store));
    chk("nvm", 16'h0000, 16'(nvm_wp));
    // Mid-run reset with the enable pin high again
    i_cond = H;
    i_nrst = 1'b0;
    #20 chk("rst_wp", 16'h0080, 16'(nvm_wp));
    chk("rst_vset", 16'h1800, vset);
    chk("alert_out", 16'h0000, 16'(al_out));
    repeat (16) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    repeat (8) @(posedge i_clk_sys);
    #1 chk("rst_on", 16'h0001, 16'(out_en));
    report_and_stop();
  end
endmodule
